// [hdl/ipsw_consts.vh]
`ifndef IPSW_CONSTS_VH
`define IPSW_CONSTS_VH
// Processor status byte layout.
`define IPSW_PST_STATE_LSB   0
`define IPSW_PST_STATE_MSB   3
`define IPSW_PST_FAULTED     4
`define IPSW_PST_REFMODE     5
`define IPSW_PST_STOPPED     6
`define IPSW_PST_BCAST       7
// Processor state codes; the rest are reserved.
`define IPSW_STATE_IDLE      4'h0
`define IPSW_STATE_EXEC      4'h1
// Process status bits.
`define IPSW_PRC_BOUND       0
`define IPSW_PRC_CTX_FLT     1
`define IPSW_PRC_PRC_FLT     2
// Processor descriptor system rights bits.
`define IPSW_SR_BCAST        0
`define IPSW_SR_LOCAL        1
// Peripheral subsystem state field layout.
`define IPSW_PSS_INHIBIT     0
`define IPSW_PSS_WSD_LSB     1
`define IPSW_PSS_WSD_MSB     3
`define IPSW_PSS_XAD_LSB     4
`define IPSW_PSS_XAD_MSB     6
// Interprocessor state field flags.
`define IPSW_IPC_LOCAL       0
`define IPSW_IPC_GLOBAL      1
// Data segment word addresses (double byte displacements).
`define IPSW_ADDR_PSS        8'h00
`define IPSW_ADDR_IPC        8'h01
`define IPSW_ADDR_PSTAT      8'h02
`define IPSW_ADDR_PID        8'h03
`define IPSW_ADDR_FUNC       8'h07
`define IPSW_ADDR_MAP        8'h1c
`define IPSW_ADDR_FLT_PRCR   8'h36
`define IPSW_ADDR_FLT_PRCS   8'h40
`define IPSW_CTRL_BASE       8'h04
`define IPSW_CTRL_WINDOW     3'h4
`endif

// [hdl/ipsw_mem.v]
`timescale 1ns/1ps
// Small word store for the processor data segment copy.
module ipsw_mem #(
  parameter AW = 8,
  parameter DW = 16
) (
  input  wire          clk_sys,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Read data are registered so the window read path has one fixed latency.
  always @(posedge clk_sys)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule

// [hdl/ipsw_top.v]
// How it works
// [R1] Process bound bit reads 0 when bound, 1 when unbound.
// [R2] Context and process faulted bits: 0 clean, 1 faulted.
// [R3] Process fault with bound process goes to the process fault area.
// [R4] Process fault with no bound process goes to the processor area.
// [R5] Mapping and function units run concurrently, neither waits.
// [R6] System rights bit 0 gates global broadcast messages.
// [R7] Middle rights bit gates local messages; high bit is ignored.
// [R8] Resident state copy is refreshed on function or block completion; the code skips it when a higher-priority copy-back takes that cycle.
// [R9] Data segment from word four up is readable through window 4.
// [R10] State code 0000 idle, 0001 executing; others reserved.
// [R11] Status faulted bit: 0 not faulted, 1 faulted.
// [R12] Reference mode 1 logical, 0 raw 24-bit physical.
// [R13] Stopped bit: 0 running, 1 stopped.
// [R14] Broadcast accept bit is 1 while broadcasts are accepted.
// [R15] Identifier is loaded at init into data and local segments; the data copy is lost when a process fault or completion takes that cycle.
// [R16] Inhibit suppresses successful completion interrupts only; others pass.
// [R17] Host delay fields set the peripheral interface timing.
// [R18] After an interprocessor signal, record it and interrupt.
// [R19] Local and global response flags read 1 once a response occurred.
// [R20] Never write a reserved state code.
`timescale 1ns/1ps
`include "ipsw_consts.vh"
module ipsw_top #(
  parameter PID_W = 8
) (
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire             init_req,
  input  wire [PID_W-1:0] pid_ext,
  input  wire             proc_bound,
  input  wire             run_req,
  input  wire             stop_req,
  input  wire             ref_logical,
  input  wire             bcast_enable,
  input  wire [2:0]       sys_rights,
  input  wire             fault_processor,
  input  wire             fault_process,
  input  wire             fault_context,
  input  wire             func_done,
  input  wire             func_ok,
  input  wire             blk_done,
  input  wire [15:0]      func_state,
  input  wire [15:0]      map_state,
  input  wire             ipc_local_sig,
  input  wire             ipc_global_sig,
  input  wire             win_rd,
  input  wire             win_wr,
  input  wire [2:0]       win_sel,
  input  wire [7:0]       win_addr,
  input  wire [15:0]      win_wdata,
  output reg  [15:0]      win_rdata,
  output reg              win_rvalid,
  output reg  [7:0]       processor_status_byte,
  output reg  [2:0]       process_status,
  output reg              fault_to_process,
  output reg              fault_to_processor,
  output reg              bcast_allowed,
  output reg              local_msg_allowed,
  output reg              host_irq,
  output reg  [2:0]       write_sample_delay,
  output reg  [2:0]       xack_delay,
  output reg  [PID_W-1:0] local_seg_pid
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for every external event and level except sys_rights, pid_ext, func_state, map_state and the window bus.
  localparam NS = 13;
  wire [NS-1:0] raw = {init_req, proc_bound, run_req, stop_req,
                       ref_logical, bcast_enable, fault_processor,
                       fault_process, fault_context, func_done, func_ok,
                       blk_done, ipc_local_sig | ipc_global_sig};
  reg  [NS-1:0] sync1;
  reg  [NS-1:0] sync2;
  reg  [NS-1:0] prev;
  reg           ipl1;
  reg           ipl2;
  reg           ipg1;
  reg           ipg2;
  reg           ipl_q;
  reg           ipg_q;

  // Two stages before anything looks at the pins.
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1 <= {NS{1'b0}};
      sync2 <= {NS{1'b0}};
      prev  <= {NS{1'b0}};
      ipl1  <= 1'b0;
      ipl2  <= 1'b0;
      ipg1  <= 1'b0;
      ipg2  <= 1'b0;
      ipl_q <= 1'b0;
      ipg_q <= 1'b0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
      prev  <= sync2;
      ipl1  <= ipc_local_sig;
      ipl2  <= ipl1;
      ipg1  <= ipc_global_sig;
      ipg2  <= ipg1;
      ipl_q <= ipl2;
      ipg_q <= ipg2;
    end
  end

  wire [NS-1:0] rise = sync2 & ~prev;
  wire s_init    = rise[12];
  wire s_bound   = sync2[11];
  wire s_run     = rise[10];
  wire s_stop    = rise[9];
  wire s_reflog  = sync2[8];
  wire s_bcen    = sync2[7];
  wire s_fprcr   = rise[6];
  wire s_fprcs   = rise[5];
  wire s_fctx    = rise[4];
  wire s_fdone   = rise[3];
  wire s_fok     = sync2[2];
  wire s_bdone   = rise[1];
  wire s_ipl     = ipl2 & ~ipl_q;
  wire s_ipg     = ipg2 & ~ipg_q;

  ////////////////////////////////////////////////////////////////////////
  // Processor status and process status state.
  reg [3:0] pstate;
  reg       faulted;
  reg       stopped;
  reg       ctx_flt;
  reg       prc_flt;
  reg       inhibit;
  reg       ipc_lresp;
  reg       ipc_gresp;

  // Only the two legal state codes are ever produced.
  function [3:0] next_state_code;
    input run;
    input bound;
    begin
      if (run && bound)
        next_state_code = `IPSW_STATE_EXEC; // see [R10] see [R20]
      else
        next_state_code = `IPSW_STATE_IDLE; // see [R10] see [R20]
    end
  endfunction

  wire host_psw = win_wr && (win_sel == `IPSW_CTRL_WINDOW) &&
                  (win_addr == `IPSW_ADDR_PSS);
  wire host_ipc = win_wr && (win_sel == `IPSW_CTRL_WINDOW) &&
                  (win_addr == `IPSW_ADDR_IPC);

  // Status flags; a new event wins over a host clear in the same cycle.
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pstate             <= `IPSW_STATE_IDLE;
      faulted            <= 1'b0;
      stopped            <= 1'b1;
      ctx_flt            <= 1'b0;
      prc_flt            <= 1'b0;
      inhibit            <= 1'b0;
      write_sample_delay <= 3'h0;
      xack_delay         <= 3'h0;
      ipc_lresp          <= 1'b0;
      ipc_gresp          <= 1'b0;
      local_seg_pid      <= {PID_W{1'b0}};
    end
    else
    begin
      if (s_init)
      begin
        local_seg_pid <= pid_ext; // see [R15]
      end
      if (s_stop)
        stopped <= 1'b1; // see [R13]
      else if (s_run)
        stopped <= 1'b0; // see [R13]
      pstate <= next_state_code(~stopped, s_bound);
      if (s_fprcr)
        faulted <= 1'b1; // see [R11]
      if (s_fctx)
        ctx_flt <= 1'b1; // see [R2]
      else if (s_run)
        ctx_flt <= 1'b0;
      if (s_fprcs)
        prc_flt <= 1'b1; // see [R2]
      else if (s_run)
        prc_flt <= 1'b0;
      if (host_psw) // see [R17]
      begin
        inhibit            <= win_wdata[`IPSW_PSS_INHIBIT]; // see [R16]
        write_sample_delay <= win_wdata[`IPSW_PSS_WSD_MSB:`IPSW_PSS_WSD_LSB];
        xack_delay         <= win_wdata[`IPSW_PSS_XAD_MSB:`IPSW_PSS_XAD_LSB];
      end
      // Interprocessor responses; a new signal wins over a host clear.
      if (s_ipl)
        ipc_lresp <= 1'b1; // see [R18] see [R19]
      else if (host_ipc && win_wdata[`IPSW_IPC_LOCAL])
        ipc_lresp <= 1'b0;
      if (s_ipg)
        ipc_gresp <= 1'b1; // see [R18] see [R19]
      else if (host_ipc && win_wdata[`IPSW_IPC_GLOBAL])
        ipc_gresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered status outputs and fault routing.
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      processor_status_byte <= 8'h00;
      process_status        <= 3'h1;
      fault_to_process      <= 1'b0;
      fault_to_processor    <= 1'b0;
      bcast_allowed         <= 1'b0;
      local_msg_allowed     <= 1'b0;
      host_irq              <= 1'b0;
    end
    else
    begin
      processor_status_byte[`IPSW_PST_STATE_MSB:`IPSW_PST_STATE_LSB]
        <= pstate; // see [R10]
      processor_status_byte[`IPSW_PST_FAULTED] <= faulted; // see [R11]
      processor_status_byte[`IPSW_PST_REFMODE] <= s_reflog; // see [R12]
      processor_status_byte[`IPSW_PST_STOPPED] <= stopped; // see [R13]
      processor_status_byte[`IPSW_PST_BCAST] <= s_bcen; // see [R14]
      process_status[`IPSW_PRC_BOUND]   <= ~s_bound; // see [R1]
      process_status[`IPSW_PRC_CTX_FLT] <= ctx_flt; // see [R2]
      process_status[`IPSW_PRC_PRC_FLT] <= prc_flt; // see [R2]
      fault_to_process   <= s_fprcs & s_bound; // see [R3]
      fault_to_processor <= s_fprcs & ~s_bound; // see [R4]
      // The high rights bit is deliberately left unread.
      bcast_allowed     <= sys_rights[`IPSW_SR_BCAST]; // see [R6]
      local_msg_allowed <= sys_rights[`IPSW_SR_LOCAL]; // see [R7]
      // Successful completion interrupts obey the inhibit; all others always pass.
      host_irq <= (s_fdone & ~(s_fok & inhibit)) | s_fprcr | s_fprcs |
                  s_fctx | s_ipl | s_ipg | s_bdone; // see [R16] see [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Copy-back into the data segment, run apart from the window path.
  reg        cb_we;
  reg [7:0]  cb_addr;
  reg [15:0] cb_data;
  reg        ipc_dirty;

  // One write per cycle; priority picks the most urgent update.
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cb_we     <= 1'b0;
      cb_addr   <= 8'h00;
      cb_data   <= 16'h0000;
      ipc_dirty <= 1'b0;
    end
    else
    begin
      cb_we     <= 1'b1;
      ipc_dirty <= ipc_dirty | s_ipl | s_ipg | host_ipc;
      if (s_fprcs)
      begin
        // see [R3] see [R4]
        cb_addr <= s_bound ? `IPSW_ADDR_FLT_PRCS : `IPSW_ADDR_FLT_PRCR;
        cb_data <= func_state;
      end
      else if (s_fdone)
      begin
        cb_addr <= `IPSW_ADDR_FUNC; // see [R8]
        cb_data <= func_state;
      end
      else if (s_bdone)
      begin
        cb_addr <= `IPSW_ADDR_MAP; // see [R8]
        cb_data <= map_state;
      end
      else if (s_init)
      begin
        cb_addr <= `IPSW_ADDR_PID; // see [R15]
        cb_data <= {{(16-PID_W){1'b0}}, pid_ext};
      end
      else if (ipc_dirty)
      begin
        // The pending mark stays set if a new change arrives right now.
        ipc_dirty <= s_ipl | s_ipg | host_ipc;
        cb_addr   <= `IPSW_ADDR_IPC; // see [R18]
        cb_data   <= {14'h0, ipc_gresp, ipc_lresp}; // see [R19]
      end
      else
      begin
        cb_we   <= 1'b0;
        cb_addr <= cb_addr;
        cb_data <= cb_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control window read path.
  wire [15:0] mem_q;
  reg         rd_q;
  reg  [7:0]  rd_addr;

  // Separate read port so window reads never stall copy-back writes.
  ipsw_mem #(
    .AW (8),
    .DW (16)
  ) u_mem (
    .clk_sys (clk_sys),
    .we      (cb_we),
    .waddr   (cb_addr),
    .wdata   (cb_data),
    .raddr   (win_addr),
    .rdata   (mem_q)
  ); // see [R5]

  wire win_ok = win_rd && (win_sel == `IPSW_CTRL_WINDOW) &&
                (win_addr >= `IPSW_CTRL_BASE); // see [R9]

  // Words from word four up come from the copy; words below word four read as zero.
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_q       <= 1'b0;
      rd_addr    <= 8'h00;
      win_rdata  <= 16'h0000;
      win_rvalid <= 1'b0;
    end
    else
    begin
      rd_q       <= win_rd && (win_sel == `IPSW_CTRL_WINDOW);
      rd_addr    <= win_ok ? win_addr : 8'h00;
      win_rvalid <= rd_q;
      if (!rd_q || rd_addr < `IPSW_CTRL_BASE)
        win_rdata <= 16'h0000; // see [R9]
      else
        win_rdata <= mem_q;
    end
  end
endmodule

// [bench/ipsw_monitor.sv]
`timescale 1ns/1ps
module ipsw_monitor #(
  parameter PID_W = 8
) (
  input wire             clk_sys,
  input wire             sys_rst,
  input wire             init_req,
  input wire [PID_W-1:0] pid_ext,
  input wire             proc_bound,
  input wire             ref_logical,
  input wire [2:0]       sys_rights,
  input wire             win_rd,
  input wire [2:0]       win_sel,
  input wire [7:0]       win_addr,
  input wire [15:0]      win_rdata,
  input wire             win_rvalid,
  input wire [7:0]       processor_status_byte,
  input wire [2:0]       process_status,
  input wire             fault_to_process,
  input wire             bcast_allowed,
  input wire             local_msg_allowed,
  input wire [PID_W-1:0] local_seg_pid
);
  reg [2:0] up;
  // Counts cycles after reset, so that level checks skip the settling time.
  always @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_bound_bit: assert property (
    (up == 3'h7 && $stable(proc_bound)) [*4]
    |-> process_status[0] == !proc_bound) else $error("bound bit wrong");
  chk_bcast_right: assert property (
    (up == 3'h7 && $stable(sys_rights)) [*4]
    |-> bcast_allowed == sys_rights[0]) else $error("broadcast right wrong");
  chk_local_right: assert property (
    (up == 3'h7 && $stable(sys_rights)) [*4]
    |-> local_msg_allowed == sys_rights[1]) else $error("local right wrong");
  chk_ref_mode: assert property (
    (up == 3'h7 && $stable(ref_logical)) [*4]
    |-> processor_status_byte[5] == ref_logical) else $error("mode wrong");
  chk_read_answer: assert property (
    win_rd && win_sel == 3'h4 |-> ##2 win_rvalid) else $error("no answer");
  chk_read_cause: assert property (
    win_rvalid |-> $past(win_rd, 2) && $past(win_sel, 2) == 3'h4)
    else $error("answer without read");
  chk_low_zero: assert property (
    win_rvalid && $past(win_addr, 2) < 8'h04 |-> win_rdata == 16'h0000)
    else $error("low word visible");
  chk_state_code: assert property (
    processor_status_byte[3:0] < 4'h2) else $error("reserved state code");
  chk_fault_sticky: assert property (
    processor_status_byte[4] |=> processor_status_byte[4])
    else $error("faulted flag cleared");
  chk_fault_route: assert property (
    fault_to_process |-> !process_status[0]) else $error("fault routed wrong");
  chk_pid_load: assert property (
    $rose(init_req) |-> ##[1:5] local_seg_pid == pid_ext)
    else $error("identifier not loaded");
  cover property (win_rvalid);
  cover property (fault_to_process);
  cover property (processor_status_byte[3:0] == 4'h1);
endmodule
bind ipsw_top ipsw_monitor #(.PID_W(PID_W)) i_mon (.clk_sys, .sys_rst,
  .init_req, .pid_ext, .proc_bound, .ref_logical, .sys_rights, .win_rd,
  .win_sel, .win_addr, .win_rdata, .win_rvalid, .processor_status_byte,
  .process_status, .fault_to_process, .bcast_allowed, .local_msg_allowed,
  .local_seg_pid);

// [bench/ipsw_host.sv]
`timescale 1ns/1ps
module ipsw_host (
  input  wire        clk_sys,
  input  wire [15:0] win_rdata,
  input  wire        win_rvalid,
  output reg         win_rd,
  output reg         win_wr,
  output reg  [2:0]  win_sel,
  output reg  [7:0]  win_addr,
  output reg  [15:0] win_wdata
);
  // Idle bus at time zero.
  initial
  begin
    {win_rd, win_wr, win_sel, win_addr, win_wdata} = 29'h0;
  end
  // Released control lines go to zero; address and data lines show the inverse of the given values.
  task release_bus(input [7:0] a, input [15:0] d);
    {win_rd, win_wr, win_sel} = 5'h00;
    win_addr = ~a;
    win_wdata = ~d;
  endtask
  // Host programs the delay and inhibit fields.
  task wr(input [7:0] a, input [15:0] d);
    @(negedge clk_sys);
    {win_wr, win_sel, win_addr, win_wdata} = {1'b1, 3'h4, a, d};
    @(negedge clk_sys);
    release_bus(a, d);
  endtask
  // Control window read, answer two cycles on.
  task rd(input [7:0] a, output [15:0] d);
    d = 16'hxxxx;
    @(negedge clk_sys);
    {win_rd, win_sel, win_addr} = {1'b1, 3'h4, a};
    @(negedge clk_sys);
    release_bus(a, 16'h0000);
    // The answer stands for one cycle, so it is looked at between edges.
    repeat (2)
    begin
      @(negedge clk_sys);
      if (win_rvalid === 1'b1)
        d = win_rdata;
    end
  endtask
endmodule

// [bench/interface_processor_status_window_test.sv]
`timescale 1ns/1ps
module interface_processor_status_window_test;
  reg         clk_sys, sys_rst, proc_bound, ref_logical, bcast_enable, func_ok;
  reg  [9:0]  pins;
  reg  [7:0]  pid_ext;
  reg  [2:0]  sys_rights;
  reg  [15:0] func_state, map_state, rd_val;
  reg  [10:0] rows [0:3];
  wire [15:0] win_rdata, win_wdata;
  wire [7:0]  processor_status_byte, win_addr, local_seg_pid;
  wire [2:0]  process_status, write_sample_delay, xack_delay, win_sel;
  wire        win_rvalid, fault_to_process, fault_to_processor, win_rd;
  wire        bcast_allowed, local_msg_allowed, host_irq, win_wr;
  integer     bad_count, total_checks, cycles, i;
  reg  [15:0] irq_n, tpc_n, tpr_n;
  ipsw_top i_dut (.clk_sys, .sys_rst, .init_req(pins[0]), .pid_ext,
    .proc_bound, .run_req(pins[1]), .stop_req(pins[2]), .ref_logical,
    .bcast_enable, .sys_rights, .fault_processor(pins[5]),
    .fault_process(pins[3]), .fault_context(pins[4]), .func_done(pins[6]),
    .func_ok, .blk_done(pins[7]), .func_state, .map_state,
    .ipc_local_sig(pins[8]), .ipc_global_sig(pins[9]), .win_rd, .win_wr,
    .win_sel, .win_addr, .win_wdata, .win_rdata, .win_rvalid,
    .processor_status_byte, .process_status, .fault_to_process,
    .fault_to_processor, .bcast_allowed, .local_msg_allowed, .host_irq,
    .write_sample_delay, .xack_delay, .local_seg_pid);
  ipsw_host i_host (.clk_sys, .win_rdata, .win_rvalid, .win_rd, .win_wr,
    .win_sel, .win_addr, .win_wdata);
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Pin events are edges, so each pulse is one cycle then settles.
  task pulse(input integer k);
    @(negedge clk_sys);
    pins[k] = 1'b1;
    @(negedge clk_sys);
    pins[k] = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask
  // Pulse outputs are counted, the bench then compares the totals.
  always @(negedge clk_sys)
  begin
    cycles = cycles + 1;
    irq_n = irq_n + (host_irq === 1'b1);
    tpc_n = tpc_n + (fault_to_process === 1'b1);
    tpr_n = tpr_n + (fault_to_processor === 1'b1);
    if (cycles == 5000)
    begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk_sys, proc_bound, ref_logical, bcast_enable, func_ok} = 5'h00;
    {pins, pid_ext, sys_rights, func_state, map_state} = 53'h0;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    {irq_n, tpc_n, tpr_n} = 48'h0;
    rows[0] = 11'h4ca;
    rows[1] = 11'h2b9;
    rows[2] = 11'h600;
    rows[3] = 11'h1ff;
    sys_rst = 1'b1;
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({8'h00, processor_status_byte}, 16'h0040);
    check({13'h0, process_status}, 16'h0001);
    for (i = 0; i < 4; i = i + 1)
    begin
      {proc_bound, sys_rights, ref_logical, bcast_enable} = rows[i][10:5];
      repeat (6) @(negedge clk_sys);
      check({11'h0, process_status[0], bcast_allowed, local_msg_allowed,
        processor_status_byte[5], processor_status_byte[7]},
        {5'h00, rows[i]} & 16'h001f);
    end
    proc_bound = 1'b1;
    pulse(1);
    check({8'h00, processor_status_byte & 8'h4f}, 16'h0001);
    pulse(2);
    check({8'h00, processor_status_byte & 8'h4f}, 16'h0040);
    pid_ext = 8'h5a;
    pulse(0);
    check({8'h00, local_seg_pid}, 16'h005a);
    // Every fault raises an interrupt too, which the totals below count.
    pulse(3);
    check(tpc_n * 16'h0010 + tpr_n, 16'h0010);
    proc_bound = 1'b0;
    pulse(3);
    pulse(4);
    check(tpc_n * 16'h0010 + tpr_n, 16'h0011);
    check({13'h0, process_status}, 16'h0007);
    pulse(1);
    check({13'h0, process_status}, 16'h0001);
    i_host.wr(8'h00, 16'h0035);
    repeat (4) @(negedge clk_sys);
    check({10'h0, write_sample_delay, xack_delay}, 16'h0013);
    {func_ok, func_state, map_state} = {1'b1, 16'h1234, 16'hbeef};
    pulse(6);
    check(irq_n, 16'h0003);
    i_host.rd(8'h07, rd_val);
    check(rd_val, 16'h1234);
    func_ok = 1'b0;
    pulse(6);
    check(irq_n, 16'h0004);
    i_host.wr(8'h00, 16'h0000);
    func_ok = 1'b1;
    pulse(6);
    check(irq_n, 16'h0005);
    pulse(7);
    i_host.rd(8'h1c, rd_val);
    check(rd_val, 16'hbeef);
    pulse(8);
    pulse(9);
    check(irq_n, 16'h0008);
    i_host.rd(8'h03, rd_val);
    check(rd_val, 16'h0000);
    pulse(5);
    check({15'h0, processor_status_byte[4]}, 16'h0001);
    // A reset in mid-run must drop the sticky fault and the identifier.
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({8'h00, processor_status_byte}, 16'h0040);
    check({13'h0, process_status}, 16'h0001);
    check({8'h00, local_seg_pid}, 16'h0000);
    end_sim;
  end
endmodule
